// >>> include/abi_params.svh
// offsets, field positions, error codes and timing counts of the bring-up block
`ifndef ABI_PARAMS_SVH
`define ABI_PARAMS_SVH
`define ABI_OFS_CMD_STATUS 5'h00
`define ABI_OFS_SOFT_RESET 5'h04
`define ABI_OFS_PRM_ADDR   5'h08
`define ABI_OFS_PRM_DATA   5'h0C
`define ABI_OFS_PRM_COUNT  5'h10
`define ABI_PAT_SOFT_RESET 16'hFF00
`define ABI_PAT_START      16'h9080
`define ABI_PRM_WORDS      4'hB
`define ABI_PW_OPT         4'h0
`define ABI_PW_VEC_A       4'h1
`define ABI_PW_VEC_B       4'h2
`define ABI_PW_VEC_C       4'h3
`define ABI_PW_RX_BURST    4'h4
`define ABI_PW_TX_BURST    4'h5
`define ABI_PW_ABORT       4'h6
`define ABI_PW_SCB_HI      4'h7
`define ABI_PW_SCB_LO      4'h8
`define ABI_PW_SSB_HI      4'h9
`define ABI_PW_SSB_LO      4'hA
`define ABI_OPT_ONE        15
`define ABI_OPT_PAR_A      14
`define ABI_OPT_PAR_B      13
`define ABI_OPT_BLOCK      12
`define ABI_OPT_LIST       11
`define ABI_OPT_LSTAT      10
`define ABI_OPT_RX         9
`define ABI_OPT_TX         8
`define ABI_ERR_SHORT      4'h1
`define ABI_ERR_OPTIONS    4'h2
`define ABI_ERR_RX_ODD     4'h3
`define ABI_ERR_TX_ODD     4'h4
`define ABI_ERR_ABORT      4'h5
`define ABI_ERR_SCB_ODD    4'h6
`define ABI_ERR_SSB_ODD    4'h7
`define ABI_ERR_DIO_PAR    4'h8
`define ABI_ERR_DMA_TMO    4'h9
`define ABI_ERR_DMA_PAR    4'hA
`define ABI_ERR_DMA_BUS    4'hB
`define ABI_ERR_DMA_DATA   4'hC
`define ABI_BYTES_SCB_RD   5'h06
`define ABI_BYTES_CLEAR    5'h02
`define ABI_BYTES_SSB_WR   5'h08
`define ABI_BYTES_STEAL    5'h02
`define ABI_BYTES_LIST_MAX 16'h001A
`define ABI_EXP_PATTERN    112'h0000C1E2D48BFFFFD1D7C5D9C3D4
`define ABI_DMA_WORDS      3'h7
`define ABI_SCB_WORDS      3'h3
`define ABI_CLK_HZ         64'd200000000
`define ABI_DMA_TMO_S      64'd10
`define ABI_DMA_TMO_CYC    (`ABI_DMA_TMO_S * `ABI_CLK_HZ)
`define ABI_SELFTEST_CYC   64'd1000
`endif

// >>> include/abi_pkg.sv
// types shared by the bring-up and initialization block
package abi_pkg;
	typedef enum logic [2:0] {
		ST_TEST, ST_READY, ST_DMA_WR, ST_DMA_RD, ST_DONE, ST_FAIL
	} abi_state_type;

	typedef struct packed {
		logic        parity_en;
		logic        block_burst_sel;
		logic        list_burst;
		logic        lstat_burst;
		logic        rx_burst;
		logic        tx_burst;
		logic [4:0]  scb_rd_bytes;
		logic [4:0]  clear_bytes;
		logic [4:0]  ssb_wr_bytes;
		logic [15:0] rx_limit;
		logic [15:0] tx_limit;
		logic [7:0]  bus_tries;
		logic [7:0]  par_tries;
		logic [47:0] vectors;
		logic [23:0] cmd_block_ptr;
		logic [23:0] status_block_ptr;
	} abi_cfg_type;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [23:0] addr;
		logic [15:0] wdata;
	} abi_dma_req_type;
endpackage

// >>> verilog/abi_timer.sv
// down counter with a level done flag, reloadable, shared by self-test and dma timeout
`timescale 1ns/1ps
module abi_timer #(
	parameter int           W       = 32,
	parameter logic [W-1:0] RST_CNT = '0
) (
	input  wire logic         clk_i,   // system clock
	input  wire logic         rst_b_i, // async reset, active low
	input  wire logic         load_i,  // restart with count_i
	input  wire logic [W-1:0] count_i, // cycles until done
	output logic              done_o   // high from expiry until next load
);
	logic [W-1:0] cnt_ff;

	// power-on reset starts a count too, so self-test runs without a load
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_ff <= RST_CNT;
			done_o <= 1'b0;
		end else if (load_i) begin
			cnt_ff <= count_i;
			done_o <= 1'b0;
		end else if (cnt_ff != '0) begin
			cnt_ff <= cnt_ff - 1'b1;
			done_o <= (cnt_ff == W'(1));
		end
	end
endmodule

// >>> verilog/abi_parity.sv
// odd parity check over a data word and its parity bit
`timescale 1ns/1ps
module abi_parity #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] data_i, // data word
	input  wire logic         par_i,  // parity bit
	output logic              ok_o    // odd count of ones
);
	assign ok_o = ^{data_i, par_i};
endmodule

// >>> verilog/abi_top.sv
// bring-up self-test reporting, parameter block check and dma test of the ring adapter
// Notes on behaviour
// - self-test restarts on hard reset line, soft reset access, or FF00 write.
// - pass sets init-ready, clears test, failure and code bits.
// - fault leaves test and failure set with a four-bit code.
// - fault codes 0 to 6 name the failing self-test stage.
// - device writes then reads back both host blocks and compares.
// - failed dma tests report an error instead of finishing.
// - both parity bits set enables odd parity checks on dio and dma.
// - block burst option gives six, two and eight byte bursts.
// - list burst option bursts the list length, at most 26 bytes.
// - list status burst option selects burst writes of list status.
// - options select burst for receive and transmit data.
// - one of six configured vectors is presented for interrupt codes 0 and 2 to 6, zero for codes 1 and 7.
// - receive burst limit, zero means whole, ignored in cycle steal.
// - transmit burst limit always applies, zero means whole transfer.
// - aborted dma retried up to bus or parity limits, zero forbidden.
// - block pointers use low 24 bits and must be even.
// - status bits: init-ready, self-test running, failure flag.
// - success clears init-ready, test and failure together.
// - bad parameters are rejected with distinct codes in the low nibble.
`timescale 1ns/1ps
`include "abi_params.svh"
module abi_top import abi_pkg::*; #(
	parameter logic [31:0] DMA_TMO_CYC  = 32'(`ABI_DMA_TMO_CYC),
	parameter logic [31:0] SELFTEST_CYC = 32'(`ABI_SELFTEST_CYC)
) (
	input  wire logic      clk_i,                  // 200 MHz system clock
	input  wire logic      rst_b_i,                // async reset, active low
	input  wire logic      host_hard_reset_line_i, // host reset drive, high
	input  wire logic [4:0]  avs_address_i,        // byte address
	input  wire logic        avs_read_i,           // read request
	input  wire logic        avs_write_i,          // write request
	input  wire logic [31:0] avs_writedata_i,      // write data
	output logic      [31:0] avs_readdata_o,       // read data
	output logic             avs_waitrequest_o,    // stall
	input  wire logic        dio_par_i,            // parity of writedata[15:0]
	input  wire logic        bist_fail_i,          // self-test saw a fault
	input  wire logic [3:0]  bist_code_i,          // fault code of self-test
	output abi_dma_req_type  dma_req_o,            // dma request to host memory
	input  wire logic        dma_ack_i,            // dma cycle finished
	input  wire logic [15:0] dma_rdata_i,          // dma read data
	input  wire logic        dma_rpar_i,           // parity of dma read data
	input  wire logic        dma_bus_err_i,        // dma ended with bus error
	input  wire logic        dma_par_err_i,        // host saw write parity error
	input  wire logic [2:0]  int_code_i,           // pending interrupt code
	output logic      [7:0]  vector_o,             // vector for the host bus
	input  wire logic [15:0] list_len_i,           // length of next list
	output logic      [4:0]  list_bytes_o,         // burst bytes for that list
	output abi_cfg_type      cfg_o                 // accepted parameters
);
	abi_state_type state_ff, nxt_state;
	logic [3:0]  code_ff, nxt_code;
	logic        init_ff, nxt_init, test_ff, nxt_test, err_ff, nxt_err;
	logic [8:0]  host_bits_ff;
	logic [15:0] prm_ff [`ABI_PRM_WORDS];
	logic [3:0]  pidx_ff, wcnt_ff;
	logic [2:0]  didx_ff, nxt_didx;
	logic [7:0]  btry_ff, nxt_btry, ptry_ff, nxt_ptry;
	abi_dma_req_type nxt_req;
	abi_cfg_type     nxt_cfg;
	logic        tmr_load, fail;
	logic [31:0] tmr_cnt;
	logic [3:0]  fail_code;

	// bus decode; an access takes effect in the cycle waitrequest is low
	wire        acc      = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
	wire        wr       = acc & avs_write_i;
	wire [15:0] wd       = avs_writedata_i[15:0];
	wire        hit_cs   = (avs_address_i == `ABI_OFS_CMD_STATUS);
	wire        hit_rst  = (avs_address_i == `ABI_OFS_SOFT_RESET);
	wire        hit_pa   = (avs_address_i == `ABI_OFS_PRM_ADDR);
	wire        hit_pd   = (avs_address_i == `ABI_OFS_PRM_DATA);
	wire        hit_cnt  = (avs_address_i == `ABI_OFS_PRM_COUNT);
	wire        soft_rst = host_hard_reset_line_i | (acc & hit_rst)
		| (wr & hit_cs & (wd == `ABI_PAT_SOFT_RESET));
	wire        start    = wr & hit_cs & (wd == `ABI_PAT_START);
	wire        cs_write = wr & hit_cs & ~soft_rst & ~start;
	wire        pd_write = wr & hit_pd & (pidx_ff < `ABI_PRM_WORDS);
	wire [15:0] csr_val  = {host_bits_ff, init_ff, test_ff, err_ff, code_ff};
	wire [15:0] prm_rd   = (pidx_ff < `ABI_PRM_WORDS) ? prm_ff[pidx_ff] : 16'h0000;
	wire [31:0] rd_mux   = hit_cs  ? {16'h0000, csr_val} :
		hit_pa  ? {28'h0000000, pidx_ff} :
		hit_pd  ? {16'h0000, prm_rd} :
		hit_cnt ? {28'h0000000, wcnt_ff} : 32'h00000000;

	// parameter block checks, first failing one wins
	wire [15:0] opt      = prm_ff[`ABI_PW_OPT];
	wire        par_on   = opt[`ABI_OPT_PAR_A] & opt[`ABI_OPT_PAR_B];
	wire        opt_bad  = ~opt[`ABI_OPT_ONE] | (opt[7:0] != 8'h00)
		| (opt[`ABI_OPT_PAR_A] != opt[`ABI_OPT_PAR_B]);
	wire        abort_z  = (prm_ff[`ABI_PW_ABORT][15:8] == 8'h00)
		| (prm_ff[`ABI_PW_ABORT][7:0] == 8'h00);
	wire [3:0]  prm_code = (wcnt_ff != `ABI_PRM_WORDS) ? `ABI_ERR_SHORT :
		opt_bad                      ? `ABI_ERR_OPTIONS :
		prm_ff[`ABI_PW_RX_BURST][0]  ? `ABI_ERR_RX_ODD  :
		prm_ff[`ABI_PW_TX_BURST][0]  ? `ABI_ERR_TX_ODD  :
		abort_z                      ? `ABI_ERR_ABORT   :
		prm_ff[`ABI_PW_SCB_LO][0]    ? `ABI_ERR_SCB_ODD :
		prm_ff[`ABI_PW_SSB_LO][0]    ? `ABI_ERR_SSB_ODD : 4'h0;
	wire        dio_ok;
	wire        dma_ok;
	wire        dio_bad  = par_on & ~dio_ok;

	// configuration taken from the block once it is accepted
	wire        blk      = opt[`ABI_OPT_BLOCK];
	abi_cfg_type prm_cfg;
	assign prm_cfg.parity_en        = par_on;
	assign prm_cfg.block_burst_sel  = blk;
	assign prm_cfg.list_burst       = opt[`ABI_OPT_LIST];
	assign prm_cfg.lstat_burst      = opt[`ABI_OPT_LSTAT];
	assign prm_cfg.rx_burst         = opt[`ABI_OPT_RX];
	assign prm_cfg.tx_burst         = opt[`ABI_OPT_TX];
	assign prm_cfg.scb_rd_bytes     = blk ? `ABI_BYTES_SCB_RD : `ABI_BYTES_STEAL;
	assign prm_cfg.clear_bytes      = blk ? `ABI_BYTES_CLEAR : `ABI_BYTES_STEAL;
	assign prm_cfg.ssb_wr_bytes     = blk ? `ABI_BYTES_SSB_WR : `ABI_BYTES_STEAL;
	// receive limit has no meaning in cycle steal, so it reads as zero there
	assign prm_cfg.rx_limit         = opt[`ABI_OPT_RX] ? prm_ff[`ABI_PW_RX_BURST] : 16'h0000;
	assign prm_cfg.tx_limit         = prm_ff[`ABI_PW_TX_BURST];
	assign prm_cfg.bus_tries        = prm_ff[`ABI_PW_ABORT][15:8];
	assign prm_cfg.par_tries        = prm_ff[`ABI_PW_ABORT][7:0];
	assign prm_cfg.vectors          = {prm_ff[`ABI_PW_VEC_A], prm_ff[`ABI_PW_VEC_B],
		prm_ff[`ABI_PW_VEC_C]};
	assign prm_cfg.cmd_block_ptr    = {prm_ff[`ABI_PW_SCB_HI][7:0], prm_ff[`ABI_PW_SCB_LO]};
	assign prm_cfg.status_block_ptr = {prm_ff[`ABI_PW_SSB_HI][7:0], prm_ff[`ABI_PW_SSB_LO]};

	// dma test word: three command block words, then four status block words
	wire        in_scb   = (didx_ff < `ABI_SCB_WORDS);
	wire [23:0] dma_addr = in_scb ? cfg_o.cmd_block_ptr + {20'h00000, didx_ff, 1'b0}
		: cfg_o.status_block_ptr + {20'h00000, didx_ff - `ABI_SCB_WORDS, 1'b0};
	wire [111:0] exp_all = `ABI_EXP_PATTERN;
	wire [15:0] exp_w    = exp_all[7'(111 - 16 * int'(didx_ff)) -: 16];
	wire        rd_phase = (state_ff == ST_DMA_RD);
	wire        par_err  = cfg_o.parity_en & (rd_phase ? ~dma_ok : dma_par_err_i);
	wire [7:0]  btry_inc = btry_ff + 8'h01;
	wire [7:0]  ptry_inc = ptry_ff + 8'h01;
	wire        tmr_done;

	// vector and list burst selection
	wire [7:0]  vec_mux  = (int_code_i == 3'h4) ? cfg_o.vectors[47:40] :
		(int_code_i == 3'h6) ? cfg_o.vectors[39:32] :
		(int_code_i == 3'h5) ? cfg_o.vectors[31:24] :
		(int_code_i == 3'h2) ? cfg_o.vectors[23:16] :
		(int_code_i == 3'h3) ? cfg_o.vectors[15:8]  :
		(int_code_i == 3'h0) ? cfg_o.vectors[7:0]   : 8'h00;
	wire [15:0] list_cap = (list_len_i > `ABI_BYTES_LIST_MAX) ? `ABI_BYTES_LIST_MAX
		: list_len_i;
	wire [4:0]  list_nxt = cfg_o.list_burst ? list_cap[4:0] : `ABI_BYTES_STEAL;

	abi_parity #(.W(16)) u_par_dio (
		.data_i (wd),
		.par_i  (dio_par_i),
		.ok_o   (dio_ok)
	);

	abi_parity #(.W(16)) u_par_dma (
		.data_i (dma_rdata_i),
		.par_i  (dma_rpar_i),
		.ok_o   (dma_ok)
	);

	abi_timer #(.W(32), .RST_CNT(SELFTEST_CYC)) u_timer (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.load_i  (tmr_load),
		.count_i (tmr_cnt),
		.done_o  (tmr_done)
	);

	always_comb begin
		nxt_state = state_ff;
		nxt_code  = code_ff;
		nxt_init  = init_ff;
		nxt_test  = test_ff;
		nxt_err   = err_ff;
		nxt_didx  = didx_ff;
		nxt_btry  = btry_ff;
		nxt_ptry  = ptry_ff;
		nxt_req   = dma_req_o;
		nxt_cfg   = cfg_o;
		tmr_load  = 1'b0;
		tmr_cnt   = SELFTEST_CYC;
		fail      = 1'b0;
		fail_code = 4'h0;
		if (soft_rst) begin
			nxt_state     = ST_TEST;
			nxt_test      = 1'b1;
			nxt_init      = 1'b0;
			nxt_err       = 1'b0;
			nxt_code      = 4'h0;
			nxt_req.valid = 1'b0;
			tmr_load      = 1'b1;
		end else begin
			unique case (state_ff)
				ST_TEST: if (tmr_done) begin
					if (bist_fail_i) begin
						fail      = 1'b1;
						fail_code = bist_code_i;
					end else begin
						nxt_state = ST_READY;
						nxt_init  = 1'b1;
						nxt_test  = 1'b0;
						nxt_err   = 1'b0;
						nxt_code  = 4'h0;
					end
				end
				ST_READY: if (start) begin
					if (dio_bad) begin
						fail      = 1'b1;
						fail_code = `ABI_ERR_DIO_PAR;
					end else if (prm_code != 4'h0) begin
						fail      = 1'b1;
						fail_code = prm_code;
					end else begin
						nxt_cfg   = prm_cfg;
						nxt_state = ST_DMA_WR;
						nxt_didx  = 3'h0;
						nxt_btry  = 8'h00;
						nxt_ptry  = 8'h00;
						tmr_load  = 1'b1;
						tmr_cnt   = DMA_TMO_CYC;
					end
				end
				ST_DMA_WR, ST_DMA_RD: begin
					if (tmr_done) begin
						fail      = 1'b1;
						fail_code = `ABI_ERR_DMA_TMO;
					end else if (!dma_req_o.valid) begin
						nxt_req.valid = 1'b1;
						nxt_req.write = ~rd_phase;
						nxt_req.addr  = {dma_addr[23:1], 1'b0};
						nxt_req.wdata = exp_w;
					end else if (dma_ack_i) begin
						nxt_req.valid = 1'b0;
						if (dma_bus_err_i) begin
							nxt_btry  = btry_inc;
							fail      = (btry_inc >= cfg_o.bus_tries);
							fail_code = `ABI_ERR_DMA_BUS;
						end else if (par_err) begin
							nxt_ptry  = ptry_inc;
							fail      = (ptry_inc >= cfg_o.par_tries);
							fail_code = `ABI_ERR_DMA_PAR;
						end else if (rd_phase && dma_rdata_i != exp_w) begin
							fail      = 1'b1;
							fail_code = `ABI_ERR_DMA_DATA;
						end else begin
							nxt_btry = 8'h00;
							nxt_ptry = 8'h00;
							nxt_didx = didx_ff + 3'h1;
							if (didx_ff == `ABI_DMA_WORDS - 3'h1) begin
								nxt_didx  = 3'h0;
								nxt_state = rd_phase ? ST_DONE : ST_DMA_RD;
								if (rd_phase) begin
									nxt_init = 1'b0;
									nxt_test = 1'b0;
									nxt_err  = 1'b0;
								end
							end
						end
					end
				end
				ST_DONE, ST_FAIL: begin
				end
			endcase
			if (fail) begin
				nxt_state     = ST_FAIL;
				nxt_err       = 1'b1;
				nxt_code      = fail_code;
				nxt_req.valid = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h00000000;
		end else begin
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
			avs_readdata_o    <= rd_mux;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= ST_TEST;
			code_ff  <= 4'h0;
			init_ff  <= 1'b0;
			test_ff  <= 1'b1;
			err_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			code_ff  <= nxt_code;
			init_ff  <= nxt_init;
			test_ff  <= nxt_test;
			err_ff   <= nxt_err;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			didx_ff   <= 3'h0;
			btry_ff   <= 8'h00;
			ptry_ff   <= 8'h00;
			dma_req_o <= '0;
			cfg_o     <= '0;
		end else begin
			didx_ff   <= nxt_didx;
			btry_ff   <= nxt_btry;
			ptry_ff   <= nxt_ptry;
			dma_req_o <= nxt_req;
			cfg_o     <= nxt_cfg;
		end
	end

	// a soft reset zeroes the word count and index but keeps the stored words, so a stale count never passes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			host_bits_ff <= 9'h000;
			pidx_ff      <= 4'h0;
			wcnt_ff      <= 4'h0;
		end else if (soft_rst) begin
			host_bits_ff <= 9'h000;
			pidx_ff      <= 4'h0;
			wcnt_ff      <= 4'h0;
		end else begin
			if (cs_write)
				host_bits_ff <= wd[15:7];
			if (wr & hit_pa)
				pidx_ff <= wd[3:0];
			else if (pd_write)
				pidx_ff <= pidx_ff + 4'h1;
			if (pd_write && wcnt_ff != `ABI_PRM_WORDS)
				wcnt_ff <= wcnt_ff + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (pd_write)
			prm_ff[pidx_ff] <= wd;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			vector_o     <= 8'h00;
			list_bytes_o <= 5'h00;
		end else begin
			vector_o     <= vec_mux;
			list_bytes_o <= list_nxt;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	chk_soft_reset_restart: assert property (
		soft_rst |=> state_ff == ST_TEST && test_ff && !init_ff && !err_ff)
		else $error("reset trigger did not restart self-test");
	chk_pass_flags: assert property (
		state_ff == ST_READY |-> init_ff && !test_ff && !err_ff && code_ff == 4'h0)
		else $error("ready state flags wrong");
	chk_fault_flags: assert property (
		$past(state_ff) == ST_TEST && state_ff == ST_FAIL && !$past(soft_rst)
		|-> test_ff && err_ff && code_ff == $past(bist_code_i))
		else $error("self-test fault not reported");
	chk_dma_order: assert property (
		state_ff == ST_DONE && $past(state_ff) != ST_DONE
		|-> $past(state_ff) == ST_DMA_RD && !init_ff && !test_ff && !err_ff)
		else $error("done reached without read-back phase");
	chk_dma_timeout: assert property (
		(state_ff == ST_DMA_WR || state_ff == ST_DMA_RD) && tmr_done && !soft_rst
		|=> state_ff == ST_FAIL && err_ff && code_ff == `ABI_ERR_DMA_TMO)
		else $error("dma timeout not reported");
	chk_param_reject: assert property (
		state_ff == ST_READY && start && !soft_rst && !dio_bad && prm_code != 4'h0
		|=> state_ff == ST_FAIL && code_ff == $past(prm_code))
		else $error("bad parameter block not rejected");
	chk_dma_even_addr: assert property (
		dma_req_o.valid |-> !dma_req_o.addr[0])
		else $error("odd dma address issued");
	chk_list_cap: assert property (
		##1 list_bytes_o <= 5'(`ABI_BYTES_LIST_MAX))
		else $error("list burst above cap");
	chk_rx_ignored: assert property (
		cfg_o.rx_limit != 16'h0000 |-> cfg_o.rx_burst)
		else $error("receive limit used in cycle steal");
	chk_vector_check: assert property (
		int_code_i == 3'h0 |=> vector_o == $past(cfg_o.vectors[7:0]))
		else $error("check vector not presented");
endmodule

// >>> dv/abi_host_mem.sv
// host memory model answering the block's dma cycles
`timescale 1ns/1ps
module abi_host_mem import abi_pkg::*; (
	input  wire logic        clk_i,   // system clock
	input  abi_dma_req_type  req_i,   // dma request from the block
	input  wire logic        bad_i,   // corrupt read data
	input  wire logic        berr_i,  // end every cycle with bus error
	output logic             ack_o,   // cycle done pulse
	output logic      [15:0] rdata_o, // read data
	output logic             rpar_o,  // odd parity of rdata_o
	output logic             berr_o   // bus error on ack
);
	logic [15:0] mem [int];

	initial ack_o = 1'b0;
	initial rdata_o = 16'h0000;
	assign rpar_o = ~^rdata_o;
	assign berr_o = berr_i & ack_o;

	always @(posedge clk_i) begin
		ack_o <= req_i.valid && !ack_o;
		// idle data toggles so stale values never look valid
		if (req_i.valid && !ack_o && !req_i.write)
			rdata_o <= mem[int'(req_i.addr)] ^ {16{bad_i}};
		else
			rdata_o <= ~rdata_o;
		if (ack_o && req_i.write && !berr_i)
			mem[int'(req_i.addr)] = req_i.wdata;
	end
endmodule

// >>> dv/abi_top_tb_top.sv
// self-checking bench of the bring-up and initialization block
`timescale 1ns/1ps
module abi_top_tb_top import abi_pkg::*;;
	logic            clk_i   = 1'b0;
	logic            rst_b_i = 1'b0;
	logic            hrst    = 1'b0;
	logic            rd      = 1'b0;
	logic            wr      = 1'b0;
	logic            par     = 1'b0;
	logic            bfail   = 1'b0;
	logic            bad     = 1'b0;
	logic            berr_en = 1'b0;
	logic            pflip   = 1'b0;
	logic            perr    = 1'b0;
	logic            mute    = 1'b0;
	logic [2:0]      icode   = 3'h0;
	logic [7:0]      vec;
	logic            ack;
	logic            rpar;
	logic            berr;
	logic            wrq;
	logic [4:0]      adr     = 5'h00;
	logic [4:0]      lbytes;
	logic [3:0]      bcode   = 4'h0;
	logic [31:0]     wdat    = 32'h0;
	logic [31:0]     rdat;
	logic [31:0]     q;
	logic [15:0]     drd;
	logic [15:0]     llen    = 16'h0028;
	logic [15:0]     p [11];
	abi_dma_req_type dreq;
	abi_cfg_type     cfg;
	int              n_fail  = 0;
	int              total_checks = 0;
	int              cyc     = 0;

	always #2.5 clk_i = ~clk_i;

	abi_top #(.DMA_TMO_CYC(32'd200), .SELFTEST_CYC(32'd20)) u_abi_top (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .host_hard_reset_line_i(hrst),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
		.dio_par_i(par), .bist_fail_i(bfail), .bist_code_i(bcode),
		.dma_req_o(dreq), .dma_ack_i(ack & !mute), .dma_rdata_i(drd), .dma_rpar_i(rpar),
		.dma_bus_err_i(berr), .dma_par_err_i(perr), .int_code_i(icode),
		.vector_o(vec), .list_len_i(llen), .list_bytes_o(lbytes), .cfg_o(cfg));

	abi_host_mem u_abi_host_mem (.clk_i(clk_i), .req_i(dreq), .bad_i(bad),
		.berr_i(berr_en), .ack_o(ack), .rdata_o(drd), .rpar_o(rpar), .berr_o(berr));

	task automatic conclude;
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		adr  <= a;
		wr   <= w;
		rd   <= !w;
		wdat <= {16'h0000, d};
		par  <= ~^d ^ pflip;
		do @(posedge clk_i); while (wrq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic st(input logic [6:0] e);
		bus(1'b0, 5'h00, 16'h0000);
		chk({25'h0, q[6:0]}, {25'h0, e});
	endtask

	task automatic boot(input logic f, input logic [3:0] c);
		@(posedge clk_i);
		bfail <= f;
		bcode <= c;
		hrst  <= 1'b1;
		@(posedge clk_i);
		hrst <= 1'b0;
		repeat (40) @(posedge clk_i);
	endtask

	task automatic init(input int n, input logic [6:0] e);
		int i;
		boot(1'b0, 4'h0);
		bus(1'b1, 5'h08, 16'h0000);
		for (i = 0; i < n; i++)
			bus(1'b1, 5'h0C, p[i]);
		bus(1'b1, 5'h00, 16'h9080);
		i = 0;
		do bus(1'b0, 5'h00, 16'h0000); while (q[6:4] === 3'b100 && ++i < 300);
		chk({25'h0, q[6:0]}, {25'h0, e});
	endtask

	task automatic t_selftest;
		for (int c = 0; c < 7; c++) begin
			boot(1'b1, 4'(c));
			st(7'h30 | 7'(c));
		end
		boot(1'b0, 4'h0);
		st(7'h40);
	endtask

	task automatic t_soft;
		bus(1'b0, 5'h04, 16'h0000);
		st(7'h20);
		repeat (40) @(posedge clk_i);
		st(7'h40);
		bus(1'b1, 5'h00, 16'hFF00);
		st(7'h20);
		repeat (40) @(posedge clk_i);
		st(7'h40);
	endtask

	task automatic t_init_ok;
		logic [15:0] ev [7] = '{16'h0000, 16'hC1E2, 16'hD48B, 16'hFFFF, 16'hD1D7,
			16'hC5D9, 16'hC3D4};
		logic [2:0]  ic [6] = '{3'h4, 3'h6, 3'h5, 3'h2, 3'h3, 3'h0};
		logic [7:0]  ve [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
		init(11, 7'h00);
		for (int i = 0; i < 7; i++)
			chk(u_abi_host_mem.mem[i < 3 ? 32'h100 + 2 * i : 32'h200 + 2 * (i - 3)],
				ev[i]);
		chk(cfg.scb_rd_bytes, 6);
		chk(cfg.clear_bytes, 2);
		chk(cfg.ssb_wr_bytes, 8);
		chk(cfg.cmd_block_ptr, 32'h100);
		chk(cfg.status_block_ptr, 32'h200);
		chk({cfg.bus_tries, cfg.par_tries}, 32'h0303);
		chk(cfg.tx_limit, 32'h20);
		chk(cfg.rx_limit, 32'h0);
		chk(lbytes, 26);
		llen <= 16'h000A;
		repeat (3) @(posedge clk_i);
		chk(lbytes, 10);
		// vector shows one cycle after the code is sampled
		for (int c = 0; c < 6; c++) begin
			@(posedge clk_i);
			icode <= ic[c];
			repeat (2) @(posedge clk_i);
			chk(vec, ve[c]);
		end
		@(posedge clk_i);
		icode <= 3'h0;
	endtask

	task automatic t_bad;
		int          ix [6] = '{4, 5, 6, 8, 10, 0};
		logic [15:0] vv [6] = '{16'h0011, 16'h0021, 16'h0000, 16'h0101, 16'h0201, 16'h1800};
		logic [6:0]  cc [6] = '{7'h53, 7'h54, 7'h55, 7'h56, 7'h57, 7'h52};
		logic [15:0] sv;
		init(10, 7'h51);
		for (int k = 0; k < 6; k++) begin
			sv = p[ix[k]];
			p[ix[k]] = vv[k];
			init(11, cc[k]);
			p[ix[k]] = sv;
		end
	endtask

	task automatic t_dma;
		bad <= 1'b1;
		init(11, 7'h5C);
		bad <= 1'b0;
		berr_en <= 1'b1;
		init(11, 7'h5B);
		berr_en <= 1'b0;
		// acks withheld: only the dma timer can end the test
		mute <= 1'b1;
		init(11, 7'h59);
		mute <= 1'b0;
	endtask

	task automatic t_parity;
		p[0] = 16'hFF00;
		p[4] = 16'h0040;
		init(11, 7'h00);
		chk({cfg.parity_en, cfg.lstat_burst, cfg.rx_burst, cfg.tx_burst}, 4'hF);
		chk(cfg.rx_limit, 32'h40);
		pflip <= 1'b1;
		init(11, 7'h58);
		pflip <= 1'b0;
		perr <= 1'b1;
		init(11, 7'h5A);
		perr <= 1'b0;
		p[0] = 16'h9800;
		p[4] = 16'h0000;
	endtask

	initial begin
		// top byte of the command block pointer is junk on purpose
		p = '{16'h9800, 16'h1122, 16'h3344, 16'h5566, 16'h0000, 16'h0020, 16'h0303,
			16'h7700, 16'h0100, 16'h0000, 16'h0200};
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_selftest();
		t_soft();
		t_init_ok();
		t_bad();
		t_dma();
		t_parity();
		conclude();
	end
endmodule
